//--- verilog/basic_timer_pkg.sv
// Package with register map, field layout and divider constants of the basic timer.
package basic_timer_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CONTROL_ADDR = 8'hd3;
  localparam logic [7:0] COUNT_ADDR   = 8'hfd;
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] COUNT_RST    = 8'h00;

  // ==========================================================================
  // Control field layout
  localparam int         WDOG_MSB     = 7;
  localparam int         WDOG_LSB     = 4;
  localparam int         SEL_MSB      = 3;
  localparam int         SEL_LSB      = 2;
  localparam int         CNT_CLR_BIT  = 1;
  localparam int         DIV_CLR_BIT  = 0;
  localparam logic [3:0] WDOG_DISABLE = 4'ha;

  // ==========================================================================
  // Clock selection and divider taps
  localparam logic [1:0] SEL_DIV4096  = 2'h0;
  localparam logic [1:0] SEL_DIV1024  = 2'h1;
  localparam logic [1:0] SEL_DIV128   = 2'h2;
  localparam logic [1:0] SEL_DIV16384 = 2'h3;
  localparam int         DIV_WIDTH    = 14;
  localparam logic [13:0] DIV_MAX     = 14'h3fff;
  localparam int         STAB_BIT     = 3;
  localparam logic [7:0] COUNT_MAX    = 8'hff;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef enum logic [1:0] {
    RUNNING,
    STOPPED,
    STABILIZING
  } timer_state_t;

endpackage : basic_timer_pkg

//--- verilog/divider_tick.sv
// Prescaler that counts while run_in is high and yields a one-cycle tick at the selected division.
module divider_tick (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       clear_in,
  input  wire logic       run_in,
  input  wire logic [1:0] sel_in,
  output logic            tick_out
);
  import basic_timer_pkg::*;

  logic [DIV_WIDTH-1:0] div_reg;
  logic [DIV_WIDTH-1:0] div_next;
  logic [DIV_WIDTH-1:0] mask;
  logic                 tick_next;

  // ==========================================================================
  // Tap selection
  assign mask = (sel_in == SEL_DIV1024)  ? 14'h03ff :
                (sel_in == SEL_DIV128)   ? 14'h007f :
                (sel_in == SEL_DIV16384) ? 14'h3fff : 14'h0fff;
  assign div_next  = clear_in ? '0 : (run_in ? div_reg + 14'h0001 : div_reg);
  assign tick_next = run_in && !clear_in && ((div_reg & mask) == mask);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg  <= '0;
      tick_out <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_out <= tick_next;
    end
  end

endmodule : divider_tick

//--- verilog/basic_timer_watchdog.sv
// Basic timer: watchdog and oscillator stabilization interval timer.

module basic_timer_watchdog (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        por_in,
  input  wire basic_timer_pkg::reg_write_t wr_in,
  input  wire logic [7:0]                  rd_addr_in,
  input  wire logic                        stop_in,
  input  wire logic                        ext_wake_in,
  output logic [7:0]                       rd_data_out,
  output logic                             system_reset_out,
  output logic                             cpu_clk_en_out,
  output logic                             stab_done_out,
  output logic                             general_timer_div_clear_out
);
  import basic_timer_pkg::*;

  logic [7:0]   control_reg;
  logic [7:0]   control_next;
  logic [7:0]   count_reg;
  logic [7:0]   count_next;
  timer_state_t state_reg;
  timer_state_t state_next;
  logic         por_wake_reg;
  logic         por_wake_next;
  logic         tick;
  logic         ctl_wr;
  logic         cnt_clr;
  logic         div_clr;
  logic         wdog_on;
  logic         overflow;
  logic         stab_ovf;
  logic         run;
  logic         wake;
  logic [1:0]   sel;
  logic [7:0]   rd_next;

  // ==========================================================================
  // Register decode
  assign ctl_wr  = wr_in.wr && (wr_in.addr == CONTROL_ADDR);
  assign cnt_clr = ctl_wr && wr_in.data[CNT_CLR_BIT];
  assign div_clr = ctl_wr && wr_in.data[DIV_CLR_BIT];
  // Clear bits are commands, never stored, so they always read back as zero.
  assign control_next = ctl_wr ? {wr_in.data[7:2], 2'b00} : control_reg;
  assign rd_next = (rd_addr_in == CONTROL_ADDR) ? control_reg :
                   (rd_addr_in == COUNT_ADDR)   ? count_reg : 8'h00;

  // ==========================================================================
  // Counting and wake-up sequence
  assign wdog_on  = control_reg[WDOG_MSB:WDOG_LSB] != WDOG_DISABLE;
  assign wake     = por_in || ext_wake_in;
  assign run      = (state_reg != STOPPED);
  assign sel      = (state_reg == STABILIZING && por_wake_reg) ? SEL_DIV4096 :
                    control_reg[SEL_MSB:SEL_LSB];
  assign overflow = tick && (count_reg == COUNT_MAX);
  assign stab_ovf = tick && (count_reg[STAB_BIT:0] == 4'hf);
  assign count_next = cnt_clr ? COUNT_RST :
                      ((state_reg == STOPPED) && wake) ? COUNT_RST :
                      tick ? count_reg + 8'h01 : count_reg;

  always_comb begin
    state_next    = state_reg;
    por_wake_next = por_wake_reg;
    case (state_reg)
      RUNNING: begin
        if (stop_in) begin
          state_next = STOPPED;
        end
      end
      STOPPED: begin
        if (wake) begin
          state_next    = STABILIZING;
          por_wake_next = por_in;
        end
      end
      STABILIZING: begin
        if (stab_ovf) begin
          state_next = RUNNING;
        end
      end
      default: begin
        state_next = RUNNING;
      end
    endcase
  end

  divider_tick u_div (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .clear_in (div_clr),
    .run_in   (run),
    .sel_in   (sel),
    .tick_out (tick)
  );

  // ==========================================================================
  // State registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_reg  <= CONTROL_RST;
      count_reg    <= COUNT_RST;
      state_reg    <= RUNNING;
      por_wake_reg <= 1'b0;
    end else begin
      control_reg  <= control_next;
      count_reg    <= count_next;
      state_reg    <= state_next;
      por_wake_reg <= por_wake_next;
    end
  end

  // ==========================================================================
  // Registered outputs
  // The reset request is a one-cycle pulse; the chip reset logic must stretch it.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out                 <= 8'h00;
      system_reset_out            <= 1'b0;
      cpu_clk_en_out              <= 1'b1;
      stab_done_out               <= 1'b0;
      general_timer_div_clear_out <= 1'b0;
    end else begin
      rd_data_out                 <= rd_next;
      system_reset_out            <= overflow && wdog_on && !cnt_clr;
      cpu_clk_en_out              <= (state_next == RUNNING);
      stab_done_out               <= (state_reg == STABILIZING) && stab_ovf;
      general_timer_div_clear_out <= div_clr;
    end
  end

endmodule : basic_timer_watchdog

//--- test/basic_timer_watchdog_properties.sv
// Port-level checks of the basic timer watchdog.
module basic_timer_watchdog_properties (
  input wire logic                        mclk_in,
  input wire logic                        rst_n_in,
  input wire logic                        por_in,
  input wire basic_timer_pkg::reg_write_t wr_in,
  input wire logic [7:0]                  rd_addr_in,
  input wire logic                        stop_in,
  input wire logic                        ext_wake_in,
  input wire logic [7:0]                  rd_data_out,
  input wire logic                        system_reset_out,
  input wire logic                        cpu_clk_en_out,
  input wire logic                        stab_done_out,
  input wire logic                        general_timer_div_clear_out
);
  import basic_timer_pkg::*;
  // ==========
  // Checks
  wire ctl_wr = wr_in.wr && wr_in.addr == CONTROL_ADDR;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence stab_end_s; $rose(cpu_clk_en_out); endsequence
  sequence cnt_clr_s; ctl_wr && wr_in.data[CNT_CLR_BIT] ##1 rd_addr_in == COUNT_ADDR; endsequence
  reset_pulse_a: assert property (system_reset_out |=> !system_reset_out) else $error("reset pulse too long");
  done_pulse_a: assert property (stab_done_out |=> !stab_done_out) else $error("done pulse too long");
  done_clock_a: assert property (stab_end_s |-> stab_done_out) else $error("clock resumed without done");
  stop_gate_a: assert property (stop_in && cpu_clk_en_out |=> !cpu_clk_en_out) else $error("clock not gated");
  div_clear_a: assert property (general_timer_div_clear_out == $past(ctl_wr && wr_in.data[DIV_CLR_BIT]))
    else $error("divider clear pulse wrong");
  self_clear_a: assert property (rd_addr_in == CONTROL_ADDR |=> rd_data_out[1:0] == 2'h0) else $error("bits not self-cleared");
  unmapped_read_a: assert property (rd_addr_in != CONTROL_ADDR && rd_addr_in != COUNT_ADDR |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  count_clear_a: assert property (cnt_clr_s |=> rd_data_out <= 8'h01) else $error("count not cleared");
endmodule : basic_timer_watchdog_properties
bind basic_timer_watchdog basic_timer_watchdog_properties chk_u (.*);

//--- test/tb_basic_timer_watchdog.sv
// Self-checking bench for the basic timer watchdog.
module tb_basic_timer_watchdog;
  timeunit 1ns;
  timeprecision 100ps;
  import basic_timer_pkg::*;
  // ==========
  // Bench
  logic       mclk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       por_in = 1'b0;
  reg_write_t wr_in = '0;
  logic [7:0] rd_addr_in = 8'h00;
  logic       stop_in = 1'b0;
  logic       ext_wake_in = 1'b0;
  logic [7:0] rd_data_out, v;
  logic       system_reset_out, cpu_clk_en_out, stab_done_out, general_timer_div_clear_out;
  int         miscompares = 0, check_count = 0, n, e, resets = 0;
  always #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (system_reset_out === 1'b1) resets++;
  basic_timer_watchdog dut_u (.*);
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in) wr_in <= '{1'b1, a, d};
    @(posedge mclk_in) wr_in.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in) rd_addr_in <= a;
    @(posedge mclk_in) #1 v = rd_data_out;
  endtask : rd
  // Phase of the prescaler is unknown, so the tick count is rounded to the nearest tick.
  task automatic wait_hi(input bit done_sel, input int lim);
    n = 0;
    while (n < lim && (done_sel ? stab_done_out : system_reset_out) !== 1'b1) @(posedge mclk_in) #1 n++;
    if (n == lim) begin
      miscompares++;
      complete_run();
    end
    e = (n + 64) / 128;
  endtask : wait_hi
  function automatic int div_of(input logic [1:0] s);
    return s == SEL_DIV4096 ? 4096 : s == SEL_DIV1024 ? 1024 : s == SEL_DIV128 ? 128 : 16384;
  endfunction : div_of
  initial begin
    void'($urandom(32'hfa9b));
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    rd(CONTROL_ADDR);
    check("control reset", v, CONTROL_RST);
    rd(8'h55);
    check("unmapped read", v, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(CONTROL_ADDR, {WDOG_DISABLE, s[1:0], 2'b11});
      repeat (div_of(s[1:0]) * 9 / 8) @(posedge mclk_in);
      rd(COUNT_ADDR);
      check("count rate", v, 8'h01);
    end
    repeat (8) begin
      e = $urandom;
      wr(CONTROL_ADDR, 8'(e));
      rd(CONTROL_ADDR);
      check("control readback", v, 8'(e) & 8'hfc);
    end
    wr(CONTROL_ADDR, 8'hab);
    wr(COUNT_ADDR, 8'hff);
    rd(COUNT_ADDR);
    check("count not writable", v, 8'h00);
    wr(CONTROL_ADDR, 8'h0b);
    wait_hi(1'b0, 40000);
    check("overflow ticks", 8'(e - 1), 8'hff);
    rd(COUNT_ADDR);
    check("count wrap", v, 8'h00);
    wr(CONTROL_ADDR, 8'hab);
    repeat (32900) @(posedge mclk_in);
    check("watchdog off", 8'(resets), 8'h01);
    @(posedge mclk_in) stop_in <= 1'b1;
    @(posedge mclk_in) stop_in <= 1'b0;
    rd(COUNT_ADDR);
    check("clock gated", 8'(cpu_clk_en_out), 8'h00);
    repeat (300) @(posedge mclk_in);
    check("count frozen", rd_data_out, v);
    @(posedge mclk_in) ext_wake_in <= 1'b1;
    @(posedge mclk_in) ext_wake_in <= 1'b0;
    wait_hi(1'b1, 3000);
    check("stab ticks", 8'(e), 8'h10);
    @(posedge mclk_in) #1;
    check("stab count", rd_data_out, 8'h10);
    check("clock resumed", 8'(cpu_clk_en_out), 8'h01);
    wr(CONTROL_ADDR, 8'hab);
    @(posedge mclk_in) stop_in <= 1'b1;
    @(posedge mclk_in) stop_in <= 1'b0;
    @(posedge mclk_in) por_in <= 1'b1;
    @(posedge mclk_in) por_in <= 1'b0;
    repeat (5120) @(posedge mclk_in);
    rd(COUNT_ADDR);
    check("por wake rate", v, 8'h01);
    check("por still halted", 8'(cpu_clk_en_out), 8'h00);
    complete_run();
  end
endmodule : tb_basic_timer_watchdog
